// ---- src/xcvr_reset_consts.svh ----
`ifndef XCVR_RESET_CONSTS_SVH
`define XCVR_RESET_CONSTS_SVH
// Device register addresses (10-bit space)
`define ADDR_AMP_CTRL 10'h018
`define ADDR_SOFT_RESET 10'h02A
`define ADDR_TX_STAB 10'h02E
`define ADDR_RADIO_CTRL 10'h036
`define ADDR_BB_REG2 10'h03A
`define ADDR_BB_REG6 10'h03E
`define ADDR_ENERGY_TH 10'h03F
`define ADDR_RCFG0 10'h200
`define ADDR_RCFG1 10'h201
`define ADDR_RCFG2 10'h202
`define ADDR_RCFG6 10'h206
`define ADDR_RCFG7 10'h207
`define ADDR_RCFG8 10'h208
`define ADDR_SLEEP_CTRL1 10'h220
// Field positions
`define BIT_PWR_RST 2
`define BIT_BB_RST 1
`define BIT_MAC_RST 0
`define BIT_RADIO_SEQ_RST 2
// Reset values of the control registers
`define RESET_VALUE 8'h00
// Initialization values
`define INIT_SOFT_RESET 8'h07
`define INIT_AMP_CTRL 8'h98
`define INIT_TX_STAB 8'h95
`define INIT_RCFG0 8'h03
`define INIT_RCFG1 8'h01
`define INIT_RCFG2 8'h80
`define INIT_RCFG6 8'h90
`define INIT_RCFG7 8'h80
`define INIT_RCFG8 8'h10
`define INIT_SLEEP_CTRL1 8'h21
`define INIT_BB_REG2 8'h80
`define INIT_ENERGY_TH 8'h60
`define INIT_BB_REG6 8'h40
`define INIT_RADIO_RST_ON 8'h04
`define INIT_RADIO_RST_OFF 8'h00
`define RCFG0_LOW_NIBBLE 4'h3
// Times (us) and clock rate (MHz)
`define CLOCK_MHZ 20
`define T_POWERUP_US 2000
`define T_PIN_RELEASE_US 250
`define T_CALIBRATE_US 192
`define CYC_POWERUP (`T_POWERUP_US * `CLOCK_MHZ)
`define CYC_PIN_RELEASE (`T_PIN_RELEASE_US * `CLOCK_MHZ)
`define CYC_CALIBRATE (`T_CALIBRATE_US * `CLOCK_MHZ)
// Controller own register map
`define CTL_REG_CMD 4'h0
`define CTL_REG_STATUS 4'h1
`define CTL_REG_CHANNEL 4'h2
`define CTL_REG_ADDR 4'h3
`define CTL_REG_DATA 4'h4
`define CTL_REG_RDATA 4'h5
`define CMD_INIT 0
`define CMD_CHANNEL 1
`define CMD_WRITE 2
`define CMD_READ 3
`define CMD_PIN_RESET 4
`endif

// ---- src/xcvr_reset_pkg.sv ----
package xcvr_reset_pkg;
  typedef logic [9:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef enum logic [1:0] {dev_in_reset, dev_release_wait, dev_running}
    dev_state_e;
endpackage

// ---- src/xcvr_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface xcvr_link_if;
  logic reset_n;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport device (input reset_n, input addr, input wdata, input wr,
    input rd, output rdata);
  modport host (output reset_n, output addr, output wdata, output wr,
    output rd, input rdata);
endinterface
`default_nettype wire

// ---- src/wait_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module wait_timer #(
  parameter int WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic i_start,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_busy
);
  logic [WIDTH-1:0] remaining;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      remaining <= '0;
    end else if (i_enable) begin
      if (i_start) begin
        remaining <= i_count;
      end else if (remaining != '0) begin
        remaining <= remaining - 1'b1;
      end
    end
  end
  assign o_busy = (remaining != '0);
endmodule // wait_timer
`default_nettype wire

// ---- src/xcvr_device_end.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "xcvr_reset_consts.svh"
module xcvr_device_end
  import xcvr_reset_pkg::*;
#(
  parameter int RELEASE_CYCLES = `CYC_PIN_RELEASE
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  xcvr_link_if.device link,
  output logic o_in_reset,
  output logic o_power_reset,
  output logic o_baseband_reset,
  output logic o_mac_reset,
  output logic o_radio_calibrating,
  output logic [7:0] o_channel_config
);
  logic [1:0] pin_sync;
  dev_state_e state;
  logic [7:0] regs [0:13];
  logic seq_rst_prev;
  logic cal_busy;
  logic cal_start;
  logic release_busy;
  logic release_start;
  logic mac_clear;
  logic [3:0] idx;
  localparam reg_addr_t MAP [0:13] = '{`ADDR_AMP_CTRL, `ADDR_SOFT_RESET,
    `ADDR_TX_STAB, `ADDR_RADIO_CTRL, `ADDR_BB_REG2, `ADDR_BB_REG6,
    `ADDR_ENERGY_TH, `ADDR_RCFG0, `ADDR_RCFG1, `ADDR_RCFG2, `ADDR_RCFG6,
    `ADDR_RCFG7, `ADDR_RCFG8, `ADDR_SLEEP_CTRL1};
  always_comb begin
    idx = 4'hF;
    for (int k = 0; k < 14; k++) begin
      if (link.addr == MAP[k]) begin
        idx = 4'(k);
      end
    end
  end
  // Pin comes from the host; two stages before any use
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_sync <= 2'b00;
    end else if (i_clk_en) begin
      pin_sync <= {pin_sync[0], link.reset_n};
    end
  end
  assign release_start = (state == dev_in_reset) && pin_sync[1];
  wait_timer #(.WIDTH(16)) u_release (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_enable(i_clk_en),
    .i_start(release_start), .i_count(16'(RELEASE_CYCLES)),
    .o_busy(release_busy));
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= dev_in_reset;
    end else if (i_clk_en) begin
      if (!pin_sync[1]) begin
        state <= dev_in_reset;
      end else begin
        case (state)
          dev_in_reset: state <= dev_release_wait;
          dev_release_wait: if (!release_busy) state <= dev_running;
          dev_running: state <= dev_running;
          default: state <= dev_in_reset;
        endcase
      end
    end
  end
  wire accept = (state == dev_running);
  wire wr_hit = accept && link.wr && (idx != 4'hF);
  assign mac_clear = wr_hit && (idx == 4'd1)
    && link.wdata[`BIT_MAC_RST];
  // Power-on (async) and pin reset restore defaults; MAC reset too
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < 14; k++) regs[k] <= `RESET_VALUE;
    end else if (i_clk_en) begin
      if (state == dev_in_reset || mac_clear) begin
        for (int k = 0; k < 14; k++) regs[k] <= `RESET_VALUE;
      end else if (wr_hit && idx != 4'd1) begin
        regs[idx] <= link.wdata;
      end
    end
  end
  // Self-clearing pulses, each bit independent
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_power_reset <= 1'b0;
      o_baseband_reset <= 1'b0;
      o_mac_reset <= 1'b0;
    end else if (i_clk_en) begin
      o_power_reset <= wr_hit && idx == 4'd1
        && link.wdata[`BIT_PWR_RST];
      o_baseband_reset <= wr_hit && idx == 4'd1
        && link.wdata[`BIT_BB_RST];
      o_mac_reset <= mac_clear;
    end
  end
  // Radio sequencer reset acts on the falling of the bit
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seq_rst_prev <= 1'b0;
    end else if (i_clk_en) begin
      seq_rst_prev <= regs[3][`BIT_RADIO_SEQ_RST];
    end
  end
  assign cal_start = seq_rst_prev && !regs[3][`BIT_RADIO_SEQ_RST];
  wait_timer #(.WIDTH(16)) u_cal (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_enable(i_clk_en),
    .i_start(cal_start), .i_count(16'(`CYC_CALIBRATE)), .o_busy(cal_busy));
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_in_reset <= 1'b1;
      o_radio_calibrating <= 1'b0;
      o_channel_config <= `RESET_VALUE;
      link.rdata <= `RESET_VALUE;
    end else if (i_clk_en) begin
      o_in_reset <= !accept;
      o_radio_calibrating <= cal_start || cal_busy;
      o_channel_config <= regs[7];
      if (accept && link.rd) begin
        // Software reset bits always read back as zero
        link.rdata <= (idx == 4'hF || idx == 4'd1) ? 8'h00 : regs[idx];
      end
    end
  end
endmodule // xcvr_device_end
`default_nettype wire

// ---- src/xcvr_host_end.sv ----
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "xcvr_reset_consts.svh"
module xcvr_host_end
  import xcvr_reset_pkg::*;
#(
  parameter int POWERUP_CYCLES = `CYC_POWERUP,
  parameter int PIN_LOW_CYCLES = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  xcvr_link_if.host link
);
  logic [4:0] step;
  logic busy;
  logic is_init;
  logic [3:0] channel;
  logic [9:0] user_addr;
  logic [7:0] user_data;
  logic [7:0] last_rdata;
  logic rd_pend;
  logic wait_start;
  logic waiting;
  logic [31:0] wait_count;
  logic [2:0] pending_cmd;
  wait_timer #(.WIDTH(32)) u_wait (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_enable(i_clk_en),
    .i_start(wait_start), .i_count(wait_count), .o_busy(waiting));
  // Sequence table: step -> address, data, wait after
  function automatic logic [49:0] seq_entry(input logic [4:0] s,
      input logic [3:0] ch);
    case (s)
      5'd0: seq_entry = {`ADDR_SOFT_RESET, `INIT_SOFT_RESET, 32'd0};
      5'd1: seq_entry = {`ADDR_AMP_CTRL, `INIT_AMP_CTRL, 32'd0};
      5'd2: seq_entry = {`ADDR_TX_STAB, `INIT_TX_STAB, 32'd0};
      5'd3: seq_entry = {`ADDR_RCFG0, `INIT_RCFG0, 32'd0};
      5'd4: seq_entry = {`ADDR_RCFG1, `INIT_RCFG1, 32'd0};
      5'd5: seq_entry = {`ADDR_RCFG2, `INIT_RCFG2, 32'd0};
      5'd6: seq_entry = {`ADDR_RCFG6, `INIT_RCFG6, 32'd0};
      5'd7: seq_entry = {`ADDR_RCFG7, `INIT_RCFG7, 32'd0};
      5'd8: seq_entry = {`ADDR_RCFG8, `INIT_RCFG8, 32'd0};
      5'd9: seq_entry = {`ADDR_SLEEP_CTRL1, `INIT_SLEEP_CTRL1, 32'd0};
      5'd10: seq_entry = {`ADDR_BB_REG2, `INIT_BB_REG2, 32'd0};
      5'd11: seq_entry = {`ADDR_ENERGY_TH, `INIT_ENERGY_TH, 32'd0};
      5'd12: seq_entry = {`ADDR_BB_REG6, `INIT_BB_REG6, 32'd0};
      5'd13: seq_entry = {`ADDR_RCFG0, ch, `RCFG0_LOW_NIBBLE, 32'd0};
      5'd14: seq_entry = {`ADDR_RADIO_CTRL, `INIT_RADIO_RST_ON, 32'd0};
      5'd15: seq_entry = {`ADDR_RADIO_CTRL, `INIT_RADIO_RST_OFF,
        32'(`CYC_CALIBRATE + 1)};
      default: seq_entry = '0;
    endcase
  endfunction
  wire [49:0] entry = seq_entry(step, channel);
  wire sw_cmd = i_wr && i_addr == `CTL_REG_CMD;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      channel <= 4'h0;
      user_addr <= 10'h000;
      user_data <= 8'h00;
    end else if (i_clk_en && i_wr) begin
      if (i_addr == `CTL_REG_CHANNEL) channel <= i_wdata[3:0];
      if (i_addr == `CTL_REG_ADDR) user_addr <= {i_wdata[1:0], 8'h00} | 10'(user_addr[7:0]);
      if (i_addr == `CTL_REG_DATA) user_data <= i_wdata;
      if (i_addr == `CTL_REG_RDATA) user_addr <= {user_addr[9:8], i_wdata};
    end
  end
  // Sequencer; starts with the pin reset and power-up wait after reset
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy <= 1'b1;
      is_init <= 1'b1;
      step <= 5'd0;
      pending_cmd <= 3'(`CMD_PIN_RESET);
      link.reset_n <= 1'b0;
      link.addr <= 10'h000;
      link.wdata <= 8'h00;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      wait_start <= 1'b0;
      wait_count <= 32'd0;
    end else if (i_clk_en) begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      wait_start <= 1'b0;
      if (!busy && sw_cmd) begin
        busy <= 1'b1;
        pending_cmd <= i_wdata[2:0];
        is_init <= (i_wdata[2:0] == 3'(`CMD_INIT));
        step <= (i_wdata[2:0] == 3'(`CMD_CHANNEL)) ? 5'd13 : 5'd0;
        if (i_wdata[2:0] == 3'(`CMD_PIN_RESET)) begin
          link.reset_n <= 1'b0;
          wait_start <= 1'b1;
          wait_count <= 32'(PIN_LOW_CYCLES);
        end
      end else if (busy && !waiting && !wait_start) begin
        if (pending_cmd == 3'(`CMD_PIN_RESET)) begin
          link.reset_n <= 1'b1;
          wait_start <= 1'b1;
          wait_count <= 32'(POWERUP_CYCLES);
          pending_cmd <= 3'(`CMD_INIT);
          is_init <= 1'b1;
          step <= 5'd0;
        end else if (pending_cmd == 3'(`CMD_WRITE)
            || pending_cmd == 3'(`CMD_READ)) begin
          link.addr <= user_addr;
          link.wdata <= user_data;
          link.wr <= (pending_cmd == 3'(`CMD_WRITE));
          link.rd <= (pending_cmd == 3'(`CMD_READ));
          busy <= 1'b0;
        end else begin
          link.addr <= entry[49:40];
          link.wdata <= entry[39:32];
          link.wr <= 1'b1;
          if (entry[31:0] != 32'd0) begin
            wait_start <= 1'b1;
            wait_count <= entry[31:0];
          end
          if (step == 5'd15) begin
            busy <= 1'b0;
          end else begin
            step <= step + 5'd1;
          end
        end
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_pend <= 1'b0;
      last_rdata <= 8'h00;
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      rd_pend <= link.rd;
      // Link read data stand from the edge after the strobe
      if (rd_pend) last_rdata <= link.rdata;
      if (i_rd) begin
        case (i_addr)
          `CTL_REG_STATUS: o_rdata <= {6'h00, is_init, busy};
          `CTL_REG_CHANNEL: o_rdata <= {4'h0, channel};
          `CTL_REG_DATA: o_rdata <= user_data;
          `CTL_REG_RDATA: o_rdata <= last_rdata;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // xcvr_host_end
`default_nettype wire

// ---- verif/xcvr_link_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "xcvr_reset_consts.svh"
module xcvr_link_monitor #(
  parameter int POWERUP_CYCLES = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic reset_n,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  int up_cnt;
  int cal_cnt;
  logic seen_wr;
  // Settle count restarts whenever the pin is pulled low
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) up_cnt <= 0;
    else if (!reset_n) up_cnt <= 0;
    else if (up_cnt < POWERUP_CYCLES) up_cnt <= up_cnt + 1;
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) seen_wr <= 1'b0;
    else if (!reset_n) seen_wr <= 1'b0;
    else if (wr) seen_wr <= 1'b1;
  end
  // Loaded by the write that ends the radio sequencer reset
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) cal_cnt <= 0;
    else if (wr && addr == `ADDR_RADIO_CTRL && wdata == 8'h00)
      cal_cnt <= `CYC_CALIBRATE - 1;
    else if (cal_cnt > 0) cal_cnt <= cal_cnt - 1;
  end
  sequence wr_at(logic [9:0] a, logic [7:0] d);
    wr && addr == a && wdata == d;
  endsequence
  sequence init_head;
    wr_at(`ADDR_SOFT_RESET, `INIT_SOFT_RESET) ##1
      wr_at(`ADDR_AMP_CTRL, `INIT_AMP_CTRL) ##1
      wr_at(`ADDR_TX_STAB, `INIT_TX_STAB);
  endsequence
  sequence radio_cfg;
    wr_at(`ADDR_RCFG1, `INIT_RCFG1) ##1 wr_at(`ADDR_RCFG2, `INIT_RCFG2) ##1
      wr_at(`ADDR_RCFG6, `INIT_RCFG6) ##1 wr_at(`ADDR_RCFG7, `INIT_RCFG7) ##1
      wr_at(`ADDR_RCFG8, `INIT_RCFG8) ##1
      wr_at(`ADDR_SLEEP_CTRL1, `INIT_SLEEP_CTRL1);
  endsequence
  sequence assess_cfg;
    wr_at(`ADDR_BB_REG2, `INIT_BB_REG2) ##1
      wr_at(`ADDR_ENERGY_TH, `INIT_ENERGY_TH) ##1
      wr_at(`ADDR_BB_REG6, `INIT_BB_REG6);
  endsequence
  a_pin_low_quiet: assert property (!reset_n |-> !wr && !rd)
    else $error("link access while reset pin low");
  a_settle_wait: assert property ((wr || rd) |-> up_cnt + 1 >= POWERUP_CYCLES)
    else $error("link access before settle time");
  a_init_first: assert property (wr && !seen_wr |->
    addr == `ADDR_SOFT_RESET && wdata == `INIT_SOFT_RESET)
    else $error("first write is not the soft reset");
  a_init_head: assert property (wr_at(`ADDR_SOFT_RESET, `INIT_SOFT_RESET)
    |-> init_head)
    else $error("init head order wrong");
  a_radio_cfg: assert property (wr_at(`ADDR_RCFG1, `INIT_RCFG1) |-> radio_cfg)
    else $error("radio config order wrong");
  a_assess_cfg: assert property (wr_at(`ADDR_BB_REG2, `INIT_BB_REG2)
    |-> assess_cfg)
    else $error("assessment config order wrong");
  a_rf_reset_pair: assert property (wr_at(`ADDR_RADIO_CTRL, 8'h04)
    |=> wr_at(`ADDR_RADIO_CTRL, 8'h00))
    else $error("sequencer reset bit not cleared");
  a_cal_quiet: assert property ((wr || rd) |-> cal_cnt == 0)
    else $error("link access during calibration");
  a_chan_nibble: assert property (wr && addr == `ADDR_RCFG0
    |-> wdata[3:0] == `RCFG0_LOW_NIBBLE)
    else $error("channel write low nibble wrong");
  a_rdata_hold: assert property (reset_n && $past(reset_n) && !$past(rd)
    |-> $stable(rdata))
    else $error("read data changed without read");
endmodule // xcvr_link_monitor
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "xcvr_reset_consts.svh"
module tb;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] o_rdata, o_channel_config, d, v, amp;
  logic [3:0] ch;
  logic o_in_reset, o_power_reset, o_baseband_reset, o_mac_reset;
  logic o_radio_calibrating;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 32'hA8331C03;
  int n_pwr = 0;
  int n_bb = 0;
  int n_mac = 0;
  int n;
  xcvr_link_if link_i();
  // Settle wait must outlast the device's release time plus its synchroniser
  xcvr_host_end #(.POWERUP_CYCLES(16), .PIN_LOW_CYCLES(4)) xcvr_host_end_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(clk_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .link(link_i.host));
  xcvr_device_end #(.RELEASE_CYCLES(8)) xcvr_device_end_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(clk_en),
    .link(link_i.device), .o_in_reset(o_in_reset),
    .o_power_reset(o_power_reset), .o_baseband_reset(o_baseband_reset),
    .o_mac_reset(o_mac_reset), .o_radio_calibrating(o_radio_calibrating),
    .o_channel_config(o_channel_config));
  xcvr_link_monitor #(.POWERUP_CYCLES(16)) xcvr_link_monitor_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .reset_n(link_i.reset_n),
    .addr(link_i.addr), .wdata(link_i.wdata), .wr(link_i.wr),
    .rd(link_i.rd), .rdata(link_i.rdata));
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  task automatic summarize();
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Pulse tally doubles as the hang limit
  always @(posedge i_clock) begin
    cycles++;
    n_pwr += int'(o_power_reset === 1'b1);
    n_bb += int'(o_baseband_reset === 1'b1);
    n_mac += int'(o_mac_reset === 1'b1);
    if (cycles == 100000) begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cw(input logic [3:0] a, input logic [7:0] wd);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= wd;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic cr(input logic [3:0] a, output logic [7:0] rd);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rd = o_rdata;
  endtask
  task automatic idle();
    logic [7:0] s;
    s = 8'h01;
    for (int k = 0; k < 9000 && s[0] !== 1'b0; k++) cr(`CTL_REG_STATUS, s);
    chk(s[0], 1'b0);
  endtask
  task automatic dev(input logic [9:0] a, input logic [7:0] wd, input bit w);
    cw(`CTL_REG_ADDR, {6'h00, a[9:8]});
    cw(`CTL_REG_DATA, wd);
    cw(`CTL_REG_RDATA, a[7:0]);
    cw(`CTL_REG_CMD, w ? 8'(`CMD_WRITE) : 8'(`CMD_READ));
    idle();
    if (!w) cr(`CTL_REG_RDATA, d);
  endtask
  function automatic logic [7:0] after_soft(input logic [7:0] sr,
      input logic [7:0] old);
    return sr[0] ? `RESET_VALUE : old;
  endfunction
  task automatic init_table();
    logic [9:0] ia [4];
    logic [7:0] iv [4];
    ia = '{`ADDR_AMP_CTRL, `ADDR_TX_STAB, `ADDR_RCFG7, `ADDR_ENERGY_TH};
    iv = '{`INIT_AMP_CTRL, `INIT_TX_STAB, `INIT_RCFG7, `INIT_ENERGY_TH};
    idle();
    for (int k = 0; k < 4; k++) begin
      dev(ia[k], 8'h00, 1'b0);
      chk(d, iv[k]);
    end
  endtask
  initial begin
    repeat (4) @(posedge i_clock);
    chk({o_in_reset, o_channel_config}, {1'b1, `RESET_VALUE});
    i_rst_b <= 1'b1;
    init_table();
    cw(4'hF, 8'h5A);
    amp = `INIT_AMP_CTRL;
    for (int i = 0; i < 7; i++) begin
      v = (i < 3) ? 8'h01 << i : 8'(1 + ($random(seed) & 32'hFF) % 6);
      amp = 8'($random(seed));
      dev(`ADDR_AMP_CTRL, amp, 1'b1);
      n_pwr = 0;
      n_bb = 0;
      n_mac = 0;
      dev(`ADDR_SOFT_RESET, v, 1'b1);
      // Pulses are tallied two edges after the status poll returns
      repeat (2) @(posedge i_clock);
      chk({n_pwr[3:0], n_bb[3:0], n_mac[3:0]}, {3'h0, v[2], 3'h0, v[1], 3'h0, v[0]});
      dev(`ADDR_SOFT_RESET, 8'h00, 1'b0);
      chk(d, 8'h00);
      amp = after_soft(v, amp);
      dev(`ADDR_AMP_CTRL, 8'h00, 1'b0);
      chk(d, amp);
    end
    for (int i = 0; i < 3; i++) begin
      ch = (i == 0) ? 4'hF : 4'($random(seed));
      cw(`CTL_REG_CHANNEL, {4'h0, ch});
      cw(`CTL_REG_CMD, 8'(`CMD_CHANNEL));
      for (n = 0; n < 200 && o_radio_calibrating !== 1'b1; n++) @(posedge i_clock);
      for (n = 0; n < 5000 && o_radio_calibrating === 1'b1; n++) begin
        @(posedge i_clock);
        #1;
      end
      chk(n >= `CYC_CALIBRATE - 1 && n <= `CYC_CALIBRATE + 1, 1'b1);
      idle();
      chk(o_channel_config, {ch, `RCFG0_LOW_NIBBLE});
      dev(`ADDR_AMP_CTRL, 8'h00, 1'b0);
      chk(d, amp);
    end
    cw(`CTL_REG_CMD, 8'(`CMD_PIN_RESET));
    for (n = 0; n < 50 && link_i.reset_n !== 1'b0; n++) @(posedge i_clock);
    for (n = 0; n < 50 && link_i.reset_n !== 1'b1; n++) @(posedge i_clock);
    #1 chk({o_in_reset, o_channel_config}, {1'b1, `RESET_VALUE});
    for (n = 0; n < 50 && o_in_reset === 1'b1; n++) begin
      @(posedge i_clock);
      #1;
    end
    chk(n >= 8 && n <= 12, 1'b1);
    init_table();
    summarize();
  end
endmodule // tb
`default_nettype wire
